// File: host_pin_watch.sv
/* Host model on the status pins: counts lock edges, feeds serial tx data.
   Assumes the pins are synchronous to pclk. */
`timescale 1ns/10ps
module host_pin_watch (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched pins
    input wire logic lock_pin,
    input wire logic ser_clk,
    // Host side
    output logic [7:0] edge_cnt,
    output logic ser_tx
);
    logic lock_q;
    logic clk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
            clk_q <= 1'b0;
            edge_cnt <= 8'h00;
            ser_tx <= 1'b0;
        end else begin
            lock_q <= lock_pin;
            clk_q <= ser_clk;
            // Lock taken on the edge, a sampled level may be stale
            if (lock_pin && !lock_q) edge_cnt <= edge_cnt + 8'h01;
            // New data only after a fall, far from the sampling rise
            if (!ser_clk && clk_q) ser_tx <= ~ser_tx;
        end
    end
endmodule

// File: pin_select_mux.sv
/*
  One output pin: picks one bit of the status signal bank by its selector,
  applies polarity inversion and registers the result.
  Assumes valid holds zero at reserved selector positions.
*/
`timescale 1ns/10ps
module pin_select_mux
    import status_pin_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Selection
    input wire logic [SEL_W-1:0] sel,
    input wire logic invert,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [BANK_W-1:0] valid,
    // Pin level
    output logic level
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (ce) begin
            // Reserved codes stay low even when inverted
            if (valid[sel]) begin
                level <= bank[sel] ^ invert;
            end else begin
                level <= 1'b0;
            end
        end
    end
endmodule

// File: status_pin_monitor.sv
/* Checker for the status pin select block: pin timing per selector code.
   Assumes it sees only the top ports; config writes are mirrored off APB. */
`timescale 1ns/10ps
module status_pin_monitor
    import status_pin_pkg::*;
(
    // Clock and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    // Radio status
    input wire logic rx_overflow,
    input wire logic rx_flush,
    input wire logic sync_found,
    input wire logic packet_crc_ok,
    input wire logic rx_start,
    input wire logic crc_done,
    input wire logic [7:0] preamble_quality_measure,
    input wire logic rssi_below,
    input wire logic receiving_packet,
    input wire logic pll_lock,
    // Pins
    input wire logic [NUM_PINS-1:0] pin_out
);
    logic [6:0] cfg_reg [NUM_PINS];
    logic [16:0] ctrl_reg;
    logic [6:0] s0;
    logic cca_exp;
    logic pq_exp;
    logic lock_exp;
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Mirror of config so pin rules can be judged from the ports alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '{default: 7'h3F};
            ctrl_reg <= 17'h0_8100;
        end else if (psel && penable && pwrite && ce) begin
            if (paddr < OFS_CTRL) begin
                cfg_reg[paddr[3:2]] <= pwdata[6:0];
            end else if (paddr == OFS_CTRL) begin
                ctrl_reg <= pwdata[16:0];
            end
        end
    end
    // A frozen block would look like a reserved code, so gate with ce
    assign s0 = ce ? cfg_reg[0] : 7'h7F;
    assign cca_exp = (!ctrl_reg[8] || rssi_below) &&
        (!ctrl_reg[9] || !receiving_packet);
    assign pq_exp = preamble_quality_measure > ctrl_reg[7:0];
    assign lock_exp = pll_lock ^ cfg_reg[0][6];

    property p_ovf_set; s0 == 7'h04 && rx_overflow |-> ##2 pin_out[0];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("ovf pin low");
    property p_ovf_clr;
        s0 == 7'h04 && rx_flush && !rx_overflow ##1 !rx_overflow
            |-> ##1 !pin_out[0];
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("ovf stuck");
    property p_sync; s0 == 7'h06 && sync_found |-> ##2 pin_out[0];
    endproperty
    a_sync: assert property (p_sync) else $error("sync pin low");
    property p_crc_pkt; s0 == 7'h07 && packet_crc_ok |-> ##2 pin_out[0];
    endproperty
    a_crc_pkt: assert property (p_crc_pkt) else $error("crc pkt low");
    property p_pq; s0 == 7'h08 |=> pin_out[0] == $past(pq_exp); endproperty
    a_pq: assert property (p_pq) else $error("pq level wrong");
    property p_cca; s0 == 7'h09 |=> pin_out[0] == $past(cca_exp); endproperty
    a_cca: assert property (p_cca) else $error("cca level wrong");
    property p_lock;
        s0[5:0] == 6'h0A |=> pin_out[0] == $past(lock_exp);
    endproperty
    a_lock: assert property (p_lock) else $error("lock wrong");
    property p_crc_clr;
        s0 == 7'h0F && rx_start && !crc_done |-> ##2 !pin_out[0];
    endproperty
    a_crc_clr: assert property (p_crc_clr) else $error("crc not clr");
    property p_ser;
        cfg_reg[1] == 7'h0B && cfg_reg[2] == 7'h0C && $changed(pin_out[2])
            |-> !pin_out[1];
    endproperty
    a_ser: assert property (p_ser) else $error("data moved on rise");
    property p_rsv; ce && cfg_reg[0][5:0] >= 6'h18 |=> !pin_out[0];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not low");

    c_ovf: cover property (s0 == 7'h04 && pin_out[0]);
    c_lock: cover property (s0 == 7'h0A && $rose(pin_out[0]));
    c_ser: cover property (cfg_reg[1] == 7'h0B && $rose(pin_out[1]));
endmodule

bind status_pin_signal_select status_pin_monitor mon (
    .pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
    .rx_overflow, .rx_flush, .sync_found, .packet_crc_ok, .rx_start,
    .crc_done, .preamble_quality_measure, .rssi_below, .receiving_packet,
    .pll_lock, .pin_out
);

// File: status_pin_pkg.sv
/*
  Package for the status pin signal select block: selector codes, register
  offsets and fields, reset values and serial clock timing.
  Assumes a single clock domain (pclk) and an APB register port.
*/
package status_pin_pkg;
    localparam int NUM_PINS = 3;
    localparam int SEL_W = 6;
    localparam int BANK_W = 64;

    // Selector codes
    localparam logic [5:0] SEL_RX_THR = 6'h00;
    localparam logic [5:0] SEL_RX_THR_END = 6'h01;
    localparam logic [5:0] SEL_TX_THR = 6'h02;
    localparam logic [5:0] SEL_RX_OVF = 6'h04;
    localparam logic [5:0] SEL_SYNC_PKT = 6'h06;
    localparam logic [5:0] SEL_CRC_PKT = 6'h07;
    localparam logic [5:0] SEL_PQ_REACHED = 6'h08;
    localparam logic [5:0] SEL_CLEAR_CHAN = 6'h09;
    localparam logic [5:0] SEL_LOCK = 6'h0A;
    localparam logic [5:0] SEL_SER_CLK = 6'h0B;
    localparam logic [5:0] SEL_SER_DATA = 6'h0C;
    localparam logic [5:0] SEL_CRC_MATCH = 6'h0F;
    localparam logic [5:0] SEL_HARD_BIT = 6'h17;

    // Register byte offsets
    localparam logic [7:0] OFS_PIN0_CFG = 8'h00;
    localparam logic [7:0] OFS_PIN1_CFG = 8'h04;
    localparam logic [7:0] OFS_PIN2_CFG = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // Field positions
    localparam int CFG_INV_BIT = 6;
    localparam int CTRL_PQ_THR_LSB = 0;
    localparam int CTRL_CCA_LSB = 8;
    localparam int CTRL_TXTHR_LSB = 10;
    localparam int STAT_LEVEL_LSB = 8;

    // Reset values
    localparam logic [5:0] RST_PIN_SEL = 6'h3F;
    localparam logic [7:0] RST_PQ_THR = 8'h00;
    localparam logic [1:0] RST_CCA = 2'h1;
    localparam logic [6:0] RST_TX_THR = 7'h20;
    localparam logic [2:0] RST_MASK = 3'h0;

    // Clear channel criteria
    localparam logic [1:0] CCA_ALWAYS = 2'h0;
    localparam logic [1:0] CCA_RSSI = 2'h1;
    localparam logic [1:0] CCA_NOT_RX = 2'h2;
    localparam logic [1:0] CCA_BOTH = 2'h3;

    // Serial clock half period in pclk cycles
    localparam logic [7:0] SER_HALF_CYCLES = 8'h04;
endpackage

// File: status_pin_signal_select.sv
/*
  Status pin signal select: radio status event tracking, per-pin signal
  selection with polarity, synchronous serial clock and data, interrupt
  status and mask, all reached over APB.
  Assumes radio status inputs are synchronous to pclk and that event inputs
  are one-cycle pulses.
*/
`timescale 1ns/10ps
module status_pin_signal_select
    import status_pin_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Radio mode
    input wire logic rx_mode,
    input wire logic tx_mode,
    input wire logic rx_start,
    // FIFO status
    input wire logic rx_fifo_at_thr,
    input wire logic rx_fifo_empty,
    input wire logic rx_overflow,
    input wire logic rx_flush,
    input wire logic rx_first_byte_read,
    input wire logic tx_underflow,
    input wire logic [6:0] tx_fifo_fill,
    // Packet engine
    input wire logic sync_found,
    input wire logic packet_end,
    input wire logic addr_reject,
    input wire logic packet_crc_ok,
    input wire logic crc_done,
    input wire logic crc_match,
    // Demodulator and synthesizer
    input wire logic [7:0] preamble_quality_measure,
    input wire logic rssi_below,
    input wire logic receiving_packet,
    input wire logic pll_lock,
    input wire logic demod_hard_bit,
    input wire logic ser_tx_in,
    // Outputs
    output logic [NUM_PINS-1:0] pin_out,
    output logic serial_tx_bit,
    output logic irq
);
    logic [SEL_W-1:0] output_pin_signal_select [NUM_PINS];
    logic [NUM_PINS-1:0] output_pin_polarity_invert;
    logic [7:0] preamble_quality_threshold;
    logic [1:0] clear_channel_criterion;
    logic [6:0] tx_thr_reg;
    logic [NUM_PINS-1:0] irq_status_reg;
    logic [NUM_PINS-1:0] irq_mask_reg;
    logic [NUM_PINS-1:0] pin_prev_reg;

    logic rx_thr_reg;
    logic rx_ovf_reg;
    logic sync_pkt_reg;
    logic crc_pkt_reg;
    logic crc_match_reg;
    logic ser_clk_reg;
    logic ser_data_reg;
    logic [7:0] ser_cnt_reg;

    logic clear_chan;
    logic [BANK_W-1:0] bank;
    logic [BANK_W-1:0] valid;

    logic setup_phase;
    logic wr_en;
    logic [NUM_PINS-1:0] pin_rise;

    assign setup_phase = psel && !penable && ce;
    assign wr_en = psel && penable && pwrite && ce;
    // Stalling the access phase keeps the bus frozen with the rest of state
    assign pready = ce;

    // Receive FIFO threshold or end of packet, until empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_thr_reg <= 1'b0;
        end else if (ce) begin
            if (rx_fifo_at_thr || packet_end) begin
                rx_thr_reg <= 1'b1;
            end else if (rx_fifo_empty) begin
                rx_thr_reg <= 1'b0;
            end
        end
    end

    // Overflow holds until flush; a new overflow beats a same-cycle flush
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ovf_reg <= 1'b0;
        end else if (ce) begin
            if (rx_overflow) begin
                rx_ovf_reg <= 1'b1;
            end else if (rx_flush) begin
                rx_ovf_reg <= 1'b0;
            end
        end
    end

    // Sync word to end of packet, with early drops in both directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_pkt_reg <= 1'b0;
        end else if (ce) begin
            if (sync_found) begin
                sync_pkt_reg <= 1'b1;
            end else if (packet_end) begin
                sync_pkt_reg <= 1'b0;
            end else if (rx_mode && (addr_reject || rx_overflow)) begin
                sync_pkt_reg <= 1'b0;
            end else if (tx_mode && tx_underflow) begin
                sync_pkt_reg <= 1'b0;
            end
        end
    end

    // Good packet waiting until the host starts reading it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_pkt_reg <= 1'b0;
        end else if (ce) begin
            if (packet_crc_ok) begin
                crc_pkt_reg <= 1'b1;
            end else if (rx_first_byte_read) begin
                crc_pkt_reg <= 1'b0;
            end
        end
    end

    // Last CRC comparison result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_match_reg <= 1'b0;
        end else if (ce) begin
            if (crc_done) begin
                crc_match_reg <= crc_match;
            end else if (rx_start) begin
                crc_match_reg <= 1'b0;
            end
        end
    end

    // Clear channel under the selected criterion
    always_comb begin
        case (clear_channel_criterion)
            CCA_ALWAYS: clear_chan = 1'b1;
            CCA_RSSI: clear_chan = rssi_below;
            CCA_NOT_RX: clear_chan = !receiving_packet;
            default: clear_chan = rssi_below && !receiving_packet;
        endcase
    end

    // Serial clock runs only in receive; idle low so the first edge rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_cnt_reg <= 8'h00;
            ser_clk_reg <= 1'b0;
        end else if (ce) begin
            if (!rx_mode) begin
                ser_cnt_reg <= 8'h00;
                ser_clk_reg <= 1'b0;
            end else if (ser_cnt_reg == SER_HALF_CYCLES - 8'h01) begin
                ser_cnt_reg <= 8'h00;
                ser_clk_reg <= !ser_clk_reg;
            end else begin
                ser_cnt_reg <= ser_cnt_reg + 8'h01;
            end
        end
    end

    // Data moves as the clock goes low, so it is stable at the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_data_reg <= 1'b0;
        end else if (ce) begin
            if (rx_mode && ser_clk_reg &&
                ser_cnt_reg == SER_HALF_CYCLES - 8'h01) begin
                ser_data_reg <= demod_hard_bit;
            end
        end
    end

    // Host data is taken as the clock goes high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_tx_bit <= 1'b0;
        end else if (ce) begin
            if (!ser_clk_reg && ser_cnt_reg == SER_HALF_CYCLES - 8'h01 &&
                rx_mode) begin
                serial_tx_bit <= ser_tx_in;
            end
        end
    end

    // Signal bank indexed by selector code; unlisted codes stay zero
    always_comb begin
        bank = '0;
        valid = '0;
        bank[SEL_RX_THR] = rx_fifo_at_thr;
        bank[SEL_RX_THR_END] = rx_thr_reg;
        bank[SEL_TX_THR] = tx_fifo_fill >= tx_thr_reg;
        bank[SEL_RX_OVF] = rx_ovf_reg;
        bank[SEL_SYNC_PKT] = sync_pkt_reg;
        bank[SEL_CRC_PKT] = crc_pkt_reg;
        bank[SEL_PQ_REACHED] =
            preamble_quality_measure > preamble_quality_threshold;
        bank[SEL_CLEAR_CHAN] = clear_chan;
        // Level passes straight; the host catches lock on its rising edge
        bank[SEL_LOCK] = pll_lock;
        bank[SEL_SER_CLK] = ser_clk_reg;
        bank[SEL_SER_DATA] = ser_data_reg;
        bank[SEL_CRC_MATCH] = crc_match_reg;
        bank[SEL_HARD_BIT] = demod_hard_bit;
        valid[SEL_RX_THR] = 1'b1;
        valid[SEL_RX_THR_END] = 1'b1;
        valid[SEL_TX_THR] = 1'b1;
        valid[SEL_RX_OVF] = 1'b1;
        valid[SEL_SYNC_PKT] = 1'b1;
        valid[SEL_CRC_PKT] = 1'b1;
        valid[SEL_PQ_REACHED] = 1'b1;
        valid[SEL_CLEAR_CHAN] = 1'b1;
        valid[SEL_LOCK] = 1'b1;
        valid[SEL_SER_CLK] = 1'b1;
        valid[SEL_SER_DATA] = 1'b1;
        valid[SEL_CRC_MATCH] = 1'b1;
        valid[SEL_HARD_BIT] = 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pin_select_mux u_mux (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .sel(output_pin_signal_select[gi]),
                .invert(output_pin_polarity_invert[gi]),
                .bank(bank),
                .valid(valid),
                .level(pin_out[gi])
            );

            // Pin configuration register
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    output_pin_signal_select[gi] <= RST_PIN_SEL;
                    output_pin_polarity_invert[gi] <= 1'b0;
                end else if (wr_en && paddr == OFS_PIN0_CFG + 8'(4 * gi)) begin
                    output_pin_signal_select[gi] <= pwdata[SEL_W-1:0];
                    output_pin_polarity_invert[gi] <= pwdata[CFG_INV_BIT];
                end
            end
        end
    endgenerate

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preamble_quality_threshold <= RST_PQ_THR;
            clear_channel_criterion <= RST_CCA;
            tx_thr_reg <= RST_TX_THR;
        end else if (wr_en && paddr == OFS_CTRL) begin
            preamble_quality_threshold <= pwdata[CTRL_PQ_THR_LSB +: 8];
            clear_channel_criterion <= pwdata[CTRL_CCA_LSB +: 2];
            tx_thr_reg <= pwdata[CTRL_TXTHR_LSB +: 7];
        end
    end

    // Interrupt: rising pin level is the event, write one to clear
    assign pin_rise = pin_out & ~pin_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_reg <= '0;
            irq_status_reg <= '0;
        end else if (ce) begin
            pin_prev_reg <= pin_out;
            if (wr_en && paddr == OFS_IRQ_STATUS) begin
                // A new event wins over a same-cycle clear
                irq_status_reg <= (irq_status_reg & ~pwdata[NUM_PINS-1:0])
                                  | pin_rise;
            end else begin
                irq_status_reg <= irq_status_reg | pin_rise;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= RST_MASK;
        end else if (wr_en && paddr == OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Read data captured in the setup phase, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == OFS_PIN0_CFG) begin
                prdata[CFG_INV_BIT:0] <= {output_pin_polarity_invert[0],
                                          output_pin_signal_select[0]};
            end else if (paddr == OFS_PIN1_CFG) begin
                prdata[CFG_INV_BIT:0] <= {output_pin_polarity_invert[1],
                                          output_pin_signal_select[1]};
            end else if (paddr == OFS_PIN2_CFG) begin
                prdata[CFG_INV_BIT:0] <= {output_pin_polarity_invert[2],
                                          output_pin_signal_select[2]};
            end else if (paddr == OFS_CTRL) begin
                prdata[CTRL_PQ_THR_LSB +: 8] <= preamble_quality_threshold;
                prdata[CTRL_CCA_LSB +: 2] <= clear_channel_criterion;
                prdata[CTRL_TXTHR_LSB +: 7] <= tx_thr_reg;
            end else if (paddr == OFS_IRQ_STATUS) begin
                prdata[NUM_PINS-1:0] <= irq_status_reg;
                prdata[STAT_LEVEL_LSB +: NUM_PINS] <= pin_out;
            end else if (paddr == OFS_IRQ_MASK) begin
                prdata[NUM_PINS-1:0] <= irq_mask_reg;
            end else begin
                // Unmapped: zero data and an error response
                pslverr <= 1'b1;
            end
        end
    end
endmodule

// File: status_pin_signal_select_tb.sv
/* Bench for the status pin select block: APB, selector table, events.
   Assumes the host model watches pins 0 and 1; ce is held high. */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    error_cnt++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module status_pin_signal_select_tb
    import status_pin_pkg::*;
;
    typedef struct packed {
        logic [6:0] cfg;
        logic [31:0] ctrl;
        logic [7:0] pqm;
        logic [6:0] fill;
        logic [3:0] lv;
        logic exp;
    } row_s;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, pqm, edges;
    logic [31:0] pwdata, prdata, rv;
    logic rx_mode, tx_mode, at_thr, empty, crc_match, rssi_below, recv;
    logic pll_lock, hard, ser_tx, serial_tx_bit, irq;
    logic [9:0] pv;
    logic [6:0] fill;
    logic [NUM_PINS-1:0] pin_out;
    int error_cnt, checks_done;
    // lv is {lock, hard bit, rssi below, receiving}
    row_s rows [11] = '{
        '{7'h0A, 32'h0000_8100, 8'h00, 7'h00, 4'h8, 1'b1},
        '{7'h4A, 32'h0000_8100, 8'h00, 7'h00, 4'h8, 1'b0},
        '{7'h17, 32'h0000_8100, 8'h00, 7'h00, 4'h4, 1'b1},
        '{7'h08, 32'h0000_8105, 8'h06, 7'h00, 4'h0, 1'b1},
        '{7'h08, 32'h0000_8105, 8'h05, 7'h00, 4'h0, 1'b0},
        '{7'h09, 32'h0000_8000, 8'h00, 7'h00, 4'h1, 1'b1},
        '{7'h09, 32'h0000_8100, 8'h00, 7'h00, 4'h2, 1'b1},
        '{7'h09, 32'h0000_8200, 8'h00, 7'h00, 4'h1, 1'b0},
        '{7'h09, 32'h0000_8300, 8'h00, 7'h00, 4'h2, 1'b1},
        '{7'h02, 32'h0000_4100, 8'h00, 7'h10, 4'h0, 1'b1},
        '{7'h7F, 32'h0000_4100, 8'h00, 7'h0F, 4'hF, 1'b0}};
    int term [4] = '{5, 6, 0, 3};

    status_pin_signal_select uut (
        .pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .rx_mode, .tx_mode, .rx_start(pv[9]),
        .rx_fifo_at_thr(at_thr), .rx_fifo_empty(empty),
        .rx_overflow(pv[0]), .rx_flush(pv[1]), .rx_first_byte_read(pv[2]),
        .tx_underflow(pv[3]), .tx_fifo_fill(fill), .sync_found(pv[4]),
        .packet_end(pv[5]), .addr_reject(pv[6]), .packet_crc_ok(pv[7]),
        .crc_done(pv[8]), .crc_match, .preamble_quality_measure(pqm),
        .rssi_below, .receiving_packet(recv), .pll_lock,
        .demod_hard_bit(hard), .ser_tx_in(ser_tx), .pin_out, .serial_tx_bit,
        .irq);
    host_pin_watch host (.pclk, .presetn, .lock_pin(pin_out[0]),
        .ser_clk(pin_out[1]), .edge_cnt(edges), .ser_tx);

    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rv, e)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // Event inputs are one-cycle pulses
    task automatic pulse(input int i);
        @(posedge pclk);
        pv[i] <= 1'b1;
        @(posedge pclk);
        pv[i] <= 1'b0;
    endtask
    task automatic ev_chk(input int i, input logic e);
        pulse(i);
        tick(3);
        `CHK(pin_out[0], e)
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pv, fill} = '0;
        {rx_mode, tx_mode, at_thr, empty, crc_match, rssi_below} = '0;
        {recv, pll_lock, hard, pqm} = '0;
        ce = 1'b1;
        repeat (12) @(posedge pclk);
        `CHK(pin_out, 3'b000)
        presetn <= 1'b1;
        rd(OFS_PIN0_CFG, 32'h0000_003F);
        rd(OFS_CTRL, 32'h0000_8100);
        rd(OFS_IRQ_MASK, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        `CHK(er, 1'b1)
        foreach (rows[i]) begin
            wr(OFS_PIN0_CFG, 32'(rows[i].cfg));
            wr(OFS_CTRL, rows[i].ctrl);
            @(posedge pclk);
            {pll_lock, hard, rssi_below, recv} <= rows[i].lv;
            pqm <= rows[i].pqm;
            fill <= rows[i].fill;
            tick(3);
            `CHK(pin_out[0], rows[i].exp)
        end
        wr(OFS_PIN0_CFG, 32'h0000_0004);
        wr(OFS_IRQ_STATUS, 32'h0000_0007);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        ev_chk(0, 1'b1);
        `CHK(irq, 1'b1)
        rd(OFS_IRQ_STATUS, 32'h0000_0101);
        ev_chk(1, 1'b0);
        wr(OFS_IRQ_STATUS, 32'h0000_0001);
        tick(2);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        ev_chk(0, 1'b1);
        tick(2);
        `CHK(irq, 1'b0)
        wr(OFS_PIN0_CFG, 32'h0000_0006);
        foreach (term[k]) begin
            {rx_mode, tx_mode} <= (term[k] == 3) ? 2'b01 : 2'b10;
            ev_chk(4, 1'b1);
            ev_chk(term[k], 1'b0);
        end
        wr(OFS_PIN0_CFG, 32'h0000_0007);
        ev_chk(7, 1'b1);
        ev_chk(2, 1'b0);
        wr(OFS_PIN0_CFG, 32'h0000_000F);
        crc_match <= 1'b1;
        ev_chk(8, 1'b1);
        crc_match <= 1'b0;
        ev_chk(8, 1'b0);
        crc_match <= 1'b1;
        ev_chk(8, 1'b1);
        ev_chk(9, 1'b0);
        wr(OFS_PIN0_CFG, 32'h0000_0001);
        // Earlier packet ends left the flag set; drain it first
        {at_thr, empty} <= 2'b01;
        tick(3);
        `CHK(pin_out[0], 1'b0)
        {at_thr, empty} <= 2'b10;
        tick(3);
        `CHK(pin_out[0], 1'b1)
        {at_thr, empty} <= 2'b01;
        tick(3);
        `CHK(pin_out[0], 1'b0)
        empty <= 1'b0;
        ev_chk(5, 1'b1);
        wr(OFS_PIN0_CFG, 32'h0000_000A);
        pll_lock <= 1'b0;
        tick(3);
        rv = 32'(edges);
        pll_lock <= 1'b1;
        tick(4);
        `CHK(edges, rv[7:0] + 8'h01)
        wr(OFS_PIN2_CFG, 32'h0000_000C);
        wr(OFS_PIN1_CFG, 32'h0000_000B);
        {rx_mode, tx_mode} <= 2'b10;
        repeat (4) begin
            while (pin_out[1] !== 1'b0) @(posedge pclk);
            // One new bit per period; the pin shows it after the next fall
            hard <= ~hard;
            while (pin_out[1] !== 1'b1) @(posedge pclk);
            tick(1);
            `CHK(serial_tx_bit, ser_tx)
            `CHK(pin_out[2], !hard)
        end
        presetn <= 1'b0;
        tick(2);
        `CHK(pin_out, 3'b000)
        presetn <= 1'b1;
        rd(OFS_PIN1_CFG, 32'h0000_003F);
        summarize();
    end
endmodule
